// ### shared/sar_adc_defines.svh
`ifndef SAR_ADC_DEFINES_SVH
`define SAR_ADC_DEFINES_SVH

// register offsets (byte addresses on the plain port)
`define ADC_ADDR_W          2
`define ADC_OFS_STATUS_CTRL 2'h0
`define ADC_OFS_RESULT      2'h1
`define ADC_OFS_CLOCK_CFG   2'h2

// status/control field positions
`define ADC_SC_DONE_BIT     7
`define ADC_SC_IRQEN_BIT    6
`define ADC_SC_CONT_BIT     5
`define ADC_SC_CH_HI        4
`define ADC_SC_CH_LO        0

// clock register field positions
`define ADC_CK_DIV_HI       7
`define ADC_CK_DIV_LO       5
`define ADC_CK_SRC_BIT      4

// reset values
`define ADC_SC_RESET        8'h1f
`define ADC_CK_RESET        8'h00
`define ADC_RESULT_RESET    8'h00

// channel codes
`define ADC_CH_PORTB_LAST   5'h07
`define ADC_CH_PORTD_LAST   5'h0e
`define ADC_CH_RESERVED     5'h1b
`define ADC_CH_REF_HIGH     5'h1d
`define ADC_CH_REF_LOW      5'h1e
`define ADC_CH_POWER_OFF    5'h1f

// timing: converter clock ticks per conversion
`define ADC_CONV_TICKS      5'd16
`define ADC_TICK_CNT_W      4

`endif

// ### shared/sar_adc_pkg.sv
package sar_adc_pkg;

  typedef enum logic [1:0]
  {
    MUX_PORT_B,
    MUX_PORT_D,
    MUX_INTERNAL,
    MUX_NONE
  } mux_group_t;

  typedef struct packed
  {
    mux_group_t  group;
    logic [2:0]  index;
    logic        refHigh;
    logic        refLow;
    logic        powerOn;
  } mux_sel_t;

  typedef struct packed
  {
    logic [1:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

endpackage

// ### rtl/sar_clock_divider.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// converter clock tick from bus or crystal clock
// ----------------------------------------------------------------
module sar_clock_divider
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       restart,
  input  wire logic       srcBus,
  input  wire logic       xtalTick,
  input  wire logic [2:0] divSel,
  output logic            tick
);

  logic       srcTick;
  logic [3:0] divCnt_r;
  logic [3:0] divLimit;

  // crystal pulses are single-cycle enables in this clock domain
  assign srcTick = srcBus ? 1'b1 : xtalTick;

  always_comb
  begin
    unique case (divSel)
      3'h0:    divLimit = 4'h0;
      3'h1:    divLimit = 4'h1;
      3'h2:    divLimit = 4'h3;
      3'h3:    divLimit = 4'h7;
      default: divLimit = 4'hf;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset || restart)
      divCnt_r <= 4'h0;
    else if (srcTick)
      divCnt_r <= (divCnt_r >= divLimit) ? 4'h0 : divCnt_r + 4'h1;
  end

  assign tick = srcTick && (divCnt_r >= divLimit);

endmodule

`default_nettype wire

// ### rtl/sar_adc_sequencer.sv
// How it works
// - continuous mode overwrites result every conversion
// - continuous bit set restarts conversion each end
// - continuous flag set first, held until clear
// - irq enabled: interrupt per conversion, flag repurposed
// - single mode flag set; write/read clears
// - irq enabled: request at end, read/write clears
// - reset clears flag, irq enable, continuous
// - clear continuous bit: one conversion per start
// - codes 0-7 port B, 8-14 port D
// - unused and reserved codes give undefined result
// - codes 1d/1e route high/low reference
// - all-ones code powers off; settle one conversion
// - wait mode keeps converting, irq wakes
// - stop mode aborts conversion, goes inactive
// - single 8-bit read-only result register
// - 3-bit prescaler selects converter clock divide
// - status/control write starts conversion unless code is all ones
// - conversion takes 16 to 17 converter clocks
// - divide 1,2,4,8; top bit set gives 16
// - clock select: 1 bus, 0 crystal, reset crystal
`timescale 1ns/1ns
`default_nettype none
`include "sar_adc_defines.svh"

module sar_adc_sequencer
  import sar_adc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [1:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdata,
  input  wire logic       xtalTick,
  input  wire logic       stopMode,
  input  wire logic       compHigh,
  output logic      [7:0] dacCode,
  output mux_sel_t        muxSel,
  output logic            sampleHold,
  output logic            converting,
  output logic            irqReq
);

  // ----------------------------------------------------------------
  // request bundle and decode
  // ----------------------------------------------------------------
  reg_req_t req;
  logic     wrCtrl;
  logic     wrClk;
  logic     rdResult;

  assign req      = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};
  assign wrCtrl   = req.wr && (req.addr == `ADC_OFS_STATUS_CTRL);
  assign wrClk    = req.wr && (req.addr == `ADC_OFS_CLOCK_CFG);
  assign rdResult = req.rd && (req.addr == `ADC_OFS_RESULT);

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic       irqEnable_r;
  logic       contMode_r;
  logic [4:0] channelSel_r;
  logic [2:0] divSel_r;
  logic       srcBus_r;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      irqEnable_r  <= 1'b0;
      contMode_r   <= 1'b0;
      channelSel_r <= 5'(`ADC_SC_RESET);
    end
    else if (wrCtrl)
    begin
      irqEnable_r  <= req.wdata[`ADC_SC_IRQEN_BIT];
      contMode_r   <= req.wdata[`ADC_SC_CONT_BIT];
      channelSel_r <= req.wdata[`ADC_SC_CH_HI:`ADC_SC_CH_LO];
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      divSel_r <= 3'h0;
      srcBus_r <= 1'b0;
    end
    else if (wrClk)
    begin
      divSel_r <= req.wdata[`ADC_CK_DIV_HI:`ADC_CK_DIV_LO];
      srcBus_r <= req.wdata[`ADC_CK_SRC_BIT];
    end
  end

  // ----------------------------------------------------------------
  // channel mux decode
  // ----------------------------------------------------------------
  logic     powerOff;
  mux_sel_t mux_nxt;

  assign powerOff = (channelSel_r == `ADC_CH_POWER_OFF);

  always_comb
  begin
    mux_nxt = '{group: MUX_NONE, index: 3'h0, refHigh: 1'b0,
                refLow: 1'b0, powerOn: !powerOff};
    if (channelSel_r <= `ADC_CH_PORTB_LAST)
    begin
      mux_nxt.group = MUX_PORT_B;
      mux_nxt.index = channelSel_r[2:0];
    end
    else if (channelSel_r <= `ADC_CH_PORTD_LAST)
    begin
      mux_nxt.group = MUX_PORT_D;
      mux_nxt.index = channelSel_r[2:0];
    end
    else if (channelSel_r == `ADC_CH_REF_HIGH)
    begin
      mux_nxt.group   = MUX_INTERNAL;
      mux_nxt.refHigh = 1'b1;
    end
    else if (channelSel_r == `ADC_CH_REF_LOW)
    begin
      mux_nxt.group  = MUX_INTERNAL;
      mux_nxt.refLow = 1'b1;
    end
    // unused and reserved codes leave the mux open: result undefined
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      muxSel <= '{group: MUX_NONE, index: 3'h0, refHigh: 1'b0,
                  refLow: 1'b0, powerOn: 1'b0};
    else
      muxSel <= mux_nxt;
  end

  // ----------------------------------------------------------------
  // converter clock
  // ----------------------------------------------------------------
  logic adcTick;

  // a control write realigns the divider phase
  sar_clock_divider u_divider
  (
    .clk      (clk),
    .reset    (reset),
    .restart  (wrCtrl),
    .srcBus   (srcBus_r),
    .xtalTick (xtalTick),
    .divSel   (divSel_r),
    .tick     (adcTick)
  );

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    ST_IDLE,
    ST_SAMPLE,
    ST_APPROX,
    ST_DONE
  } conv_state_t;

  conv_state_t state_r;
  logic [3:0]  tickCnt_r;
  logic [7:0]  sar_r;
  logic [2:0]  bitIdx_r;
  logic        convEnd;

  assign convEnd = (state_r == ST_DONE);

  always_ff @(posedge clk)
  begin
    // stop mode: drop everything, converter inactive
    if (reset || stopMode)
    begin
      state_r   <= ST_IDLE;
      tickCnt_r <= 4'h0;
      sar_r     <= 8'h00;
      bitIdx_r  <= 3'h7;
    end
    // a control write abandons any conversion in flight
    else if (wrCtrl)
    begin
      if (req.wdata[`ADC_SC_CH_HI:`ADC_SC_CH_LO] == `ADC_CH_POWER_OFF)
        state_r <= ST_IDLE;
      else
        state_r <= ST_SAMPLE;
      tickCnt_r <= 4'h0;
      sar_r     <= 8'h00;
      bitIdx_r  <= 3'h7;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
          state_r <= ST_IDLE;
        ST_SAMPLE:
          if (adcTick)
          begin
            // eight ticks sample, eight ticks approximate: 16 ticks
            // plus divider phase gives 16 to 17
            tickCnt_r <= tickCnt_r + 4'h1;
            if (tickCnt_r == 4'h7)
            begin
              state_r  <= ST_APPROX;
              sar_r    <= 8'h80;
            end
          end
        ST_APPROX:
          if (adcTick)
          begin
            tickCnt_r <= tickCnt_r + 4'h1;
            sar_r[bitIdx_r] <= compHigh;
            if (bitIdx_r != 3'h0)
            begin
              sar_r[bitIdx_r - 3'h1] <= 1'b1;
              bitIdx_r <= bitIdx_r - 3'h1;
            end
            else
              state_r <= ST_DONE;
          end
        // one cycle to load the result, then resample or rest
        ST_DONE:
        begin
          tickCnt_r <= 4'h0;
          sar_r     <= 8'h00;
          bitIdx_r  <= 3'h7;
          state_r   <= contMode_r ? ST_SAMPLE : ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // trial code and status outputs
  // ----------------------------------------------------------------
  // trial code comes straight from the SAR flops, so the comparator
  // always judges the bit being tried on this tick
  assign dacCode = sar_r;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sampleHold <= 1'b0;
      converting <= 1'b0;
    end
    else
    begin
      sampleHold <= (state_r == ST_SAMPLE);
      converting <= (state_r != ST_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // result, flag and interrupt
  // ----------------------------------------------------------------
  logic [7:0] result_r;
  logic       doneFlag_r;
  logic       firstDone_r;

  always_ff @(posedge clk)
  begin
    if (reset)
      result_r <= `ADC_RESULT_RESET;
    else if (convEnd)
      result_r <= sar_r;
  end

  // first-done tracks the first end after a start in continuous mode
  always_ff @(posedge clk)
  begin
    if (reset || wrCtrl)
      firstDone_r <= 1'b0;
    else if (convEnd)
      firstDone_r <= 1'b1;
  end

  // set wins over a clear arriving in the same cycle
  // continuous mode re-sets only while still set: a clear sticks
  always_ff @(posedge clk)
  begin
    if (reset)
      doneFlag_r <= 1'b0;
    else if (convEnd && !irqEnable_r
             && (!contMode_r || !firstDone_r || doneFlag_r))
      doneFlag_r <= 1'b1;
    else if (wrCtrl || rdResult)
      doneFlag_r <= 1'b0;
    else if (irqEnable_r)
      doneFlag_r <= 1'b0;
  end

  // interrupt also serves as the wake source in wait mode
  always_ff @(posedge clk)
  begin
    if (reset)
      irqReq <= 1'b0;
    else if (convEnd && irqEnable_r)
      irqReq <= 1'b1;
    else if (wrCtrl || rdResult || !irqEnable_r)
      irqReq <= 1'b0;
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
      regRdata <= 8'h00;
    else if (req.rd)
    begin
      unique case (req.addr)
        `ADC_OFS_STATUS_CTRL:
          regRdata <= {doneFlag_r, irqEnable_r, contMode_r, channelSel_r};
        `ADC_OFS_RESULT:
          regRdata <= result_r;
        `ADC_OFS_CLOCK_CFG:
          regRdata <= {divSel_r, srcBus_r, 4'h0};
        // unmapped space reads zero
        default:
          regRdata <= 8'h00;
      endcase
    end
    else
      regRdata <= 8'h00;
  end

endmodule

`default_nettype wire

// ### tb/sar_adc_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module sar_adc_checker
  import sar_adc_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset,
  input wire logic [1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWr,
  input wire logic       regRd,
  input wire logic [7:0] regRdata,
  input wire logic       stopMode,
  input wire mux_sel_t   muxSel,
  input wire logic       converting,
  input wire logic       irqReq
);
  // ------------------------------
  // shadow of interrupt enable
  // ------------------------------
  logic ienR;
  logic wrSc;
  assign wrSc = regWr && regAddr == 2'h0;
  always_ff @(posedge clk)
  begin
    if (reset)
      ienR <= 1'b0;
    else if (wrSc)
      ienR <= regWdata[6];
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  irq_off_a:
    assert property (!ienR && !$past(ienR) |-> !irqReq)
    else $error("irq while disabled");
  rd_clear_a:
    assert property ((!converting)[*3] ##0 (regRd && regAddr == 2'h1)
      |=> !irqReq) else $error("irq kept after read");
  rdata_idle_a:
    assert property (!$past(regRd) |-> regRdata == 8'h00)
    else $error("read data without read");
  unmapped_rd_a:
    assert property (regRd && regAddr == 2'h3 |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
  wr_start_a:
    assert property (wrSc && !stopMode && regWdata[4:0] != 5'h1f
      ##1 (!stopMode && !regWr)[*3] |-> converting)
    else $error("write did not start");
  stop_idle_a:
    assert property (stopMode[*3] |-> !converting)
    else $error("busy in stop");
  off_code_a:
    assert property (wrSc && regWdata[4:0] == 5'h1f
      |-> ##[1:2] !muxSel.powerOn) else $error("not powered off");
  ref_high_a:
    assert property (wrSc && regWdata[4:0] == 5'h1d
      |-> ##[1:2] muxSel.refHigh) else $error("high ref not routed");

  cover property (irqReq);
  cover property (stopMode && converting);
  cover property ($fell(converting));
endmodule

bind sar_adc_sequencer sar_adc_checker sar_adc_checker_i
(
  .clk(clk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .stopMode(stopMode), .muxSel(muxSel), .converting(converting),
  .irqReq(irqReq)
);
`default_nettype wire

// ### tb/test_sar_adc_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
module test_sar_adc_sequencer
  import sar_adc_pkg::*;
;
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic [1:0] regAddr = 2'h0;
  logic [7:0] regWdata = 8'h00;
  logic       regWr = 1'b0;
  logic       regRd = 1'b0;
  logic       xtalTick = 1'b0;
  logic       stopMode = 1'b0;
  logic [7:0] ain = 8'h00;
  logic [7:0] regRdata;
  logic [7:0] dacCode;
  mux_sel_t   muxSel;
  logic       sampleHold;
  logic       converting;
  logic       irqReq;
  logic       compHigh;
  int         errCount = 0;
  int         nTests = 0;
  int         c;

  // comparator: analog level against trial code
  assign compHigh = ain >= dacCode;

  sar_adc_sequencer sar_adc_sequencer_i
  (
    .clk(clk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .xtalTick(xtalTick), .stopMode(stopMode), .compHigh(compHigh),
    .dacCode(dacCode), .muxSel(muxSel), .sampleHold(sampleHold),
    .converting(converting), .irqReq(irqReq)
  );

  initial
  begin
    forever #5 clk = ~clk;
  end

  // crystal runs at half the bus rate
  always @(posedge clk)
    xtalTick <= ~xtalTick;

  // ------------------------------
  // access and compare tasks
  // ------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
  begin
    nTests++;
    if (got !== exp)
    begin
      errCount++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
  begin
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  end
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] e);
  begin
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk(regRdata, e);
    @(posedge clk);
  end
  endtask

  // waits for the end of a conversion, checks its length
  task automatic cnv(input int dv);
  begin
    c = 0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(8'(sampleHold), 8'h01);
    while (converting === 1'b1 && c < 900)
    begin
      @(negedge clk);
      c++;
    end
    repeat (3) @(posedge clk);
    chk(8'(c >= 16 * dv - 4 && c <= 17 * dv + 2), 8'h01);
  end
  endtask

  task automatic chm(input logic [7:0] d, e, m);
  begin
    wr(0, d);
    @(posedge clk);
    @(negedge clk);
    chk(8'(muxSel) & m, e);
    @(posedge clk);
  end
  endtask

  task automatic stopTest();
  begin
    $display("errors %0d checks %0d", errCount, nTests);
    if (errCount == 0 && nTests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    errCount++;
    stopTest();
  end

  initial
  begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    rd(0, 8'h1f);
    rd(2, 8'h00);
    rd(1, 8'h00);
    for (int k = 0; k < 8; k++)
    begin
      ain <= 8'(k * 37);
      wr(2, {3'(k), 5'h10});
      rd(2, {3'(k), 5'h10});
      wr(0, 8'h03);
      cnv(k > 3 ? 16 : 1 << k);
      rd(0, 8'h83);
      rd(1, 8'(k * 37));
      rd(0, 8'h03);
    end
    wr(2, 8'h00);
    wr(0, 8'h03);
    cnv(2);
    wr(2, 8'h10);
    ain <= 8'h3c;
    wr(0, 8'h03);
    repeat (6) @(posedge clk);
    ain <= 8'hc3;
    wr(0, 8'h04);
    cnv(1);
    rd(1, 8'hc3);
    chm(8'h00, 8'h01, 8'hff);
    chm(8'h07, 8'h39, 8'hff);
    chm(8'h08, 8'h41, 8'hff);
    chm(8'h0e, 8'h71, 8'hff);
    chm(8'h1d, 8'h85, 8'he7);
    chm(8'h1e, 8'h83, 8'he7);
    chm(8'h1f, 8'h00, 8'h01);
    chk(8'(converting), 8'h00);
    ain <= 8'h5a;
    wr(0, 8'h41);
    cnv(1);
    chk(8'(irqReq), 8'h01);
    rd(0, 8'h41);
    rd(1, 8'h5a);
    chk(8'(irqReq), 8'h00);
    wr(0, 8'h41);
    cnv(1);
    wr(0, 8'h01);
    @(posedge clk);
    chk(8'(irqReq), 8'h00);
    cnv(1);
    chk(8'(irqReq), 8'h00);
    ain <= 8'h11;
    wr(0, 8'h25);
    repeat (40) @(posedge clk);
    rd(0, 8'ha5);
    ain <= 8'h22;
    repeat (40) @(posedge clk);
    rd(1, 8'h22);
    ain <= 8'h33;
    repeat (40) @(posedge clk);
    rd(1, 8'h33);
    rd(0, 8'h25);
    wr(0, 8'h05);
    cnv(1);
    repeat (40) @(posedge clk);
    chk(8'(converting), 8'h00);
    rd(0, 8'h85);
    wr(0, 8'h03);
    repeat (5) @(posedge clk);
    stopMode <= 1'b1;
    repeat (4) @(posedge clk);
    chk(8'(converting), 8'h00);
    rd(0, 8'h03);
    stopMode <= 1'b0;
    wr(0, 8'h03);
    cnv(1);
    wr(3, 8'hff);
    wr(1, 8'h00);
    wr(0, 8'h9f);
    rd(3, 8'h00);
    rd(1, 8'h33);
    rd(0, 8'h1f);
    rd(2, 8'h10);
    stopTest();
  end
endmodule
`default_nettype wire
